// *** rtl/sfdiag_pkg.sv ***
// constants, modes and state layout for the safety i/o diagnostic block
package sfdiag_pkg;
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned TP_WIDTH_NS = 85000;
  localparam int unsigned TP_PERIOD_NS = 340000;
  // a least pulse width rounds up, the period is a fixed repeat
  localparam int unsigned TP_WIDTH_CYC = (TP_WIDTH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned TP_PERIOD_CYC = (TP_PERIOD_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned TP_CNT_W = 18;
  localparam int unsigned CUR_W = 16;
  localparam logic [TP_CNT_W-1:0] TP_CNT_RST = 18'h00000;
  localparam logic [1:0] DRIVE_RST = 2'h0;

  typedef enum logic [2:0] {
    SFDIAG_DO_SINGLE,
    SFDIAG_DO_SINGLE_EXT_RB,
    SFDIAG_DO_SINGLE_INT_TP,
    SFDIAG_DO_SINGLE_EXT_TP,
    SFDIAG_DO_DUAL,
    SFDIAG_DO_DUAL_INT_TP,
    SFDIAG_DO_DUAL_EXT_TP
  } sfdiag_do_mode_t;

  typedef enum logic [1:0] {
    SFDIAG_AI_SINGLE,
    SFDIAG_AI_1OO2,
    SFDIAG_AI_2OO3
  } sfdiag_ai_mode_t;

  // declaration order gives lolo < normal < high high
  typedef enum logic [1:0] {
    SFDIAG_REG_LOLO,
    SFDIAG_REG_NORM,
    SFDIAG_REG_HIHI
  } sfdiag_region_t;

  typedef struct packed {
    logic oc;
    logic open;
    logic readback;
    logic test_pulse;
  } sfdiag_do_flags_t;

  typedef struct packed {
    logic overcurrent;
    logic disc_fault;
    logic disc_warn;
  } sfdiag_ai_flags_t;

  typedef struct packed {
    logic [TP_CNT_W-1:0] tp_cnt;
    logic [1:0] drive;
    sfdiag_do_flags_t do_flags;
    sfdiag_region_t region;
    sfdiag_region_t [2:0] ch_region;
    sfdiag_ai_flags_t ai_flags;
    logic [1:0] tp_bad;
  } sfdiag_state_t;
endpackage

// *** rtl/sfdiag_top.sv ***
// fault classification for safety digital outputs and analog current inputs
`timescale 1ns/100ps
module sfdiag_top #(
  parameter int unsigned TP_WIDTH_CYC = sfdiag_pkg::TP_WIDTH_CYC,
  parameter int unsigned TP_PERIOD_CYC = sfdiag_pkg::TP_PERIOD_CYC
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // digital output command and configuration
  input wire logic cmd_i,
  input wire sfdiag_pkg::sfdiag_do_mode_t do_mode_i,
  // sensed output lines and returning input channel
  input wire logic [1:0] line_lvl_i,
  input wire logic [1:0] line_oc_i,
  input wire logic [1:0] line_load_i,
  input wire logic ret_lvl_i,
  input wire logic ret_oc_i,
  // digital output drive and flags
  output logic [1:0] do_drive_o,
  output sfdiag_pkg::sfdiag_do_flags_t do_flags_o,
  // analog configuration and measured currents
  input wire sfdiag_pkg::sfdiag_ai_mode_t ai_mode_i,
  input wire logic [2:0][sfdiag_pkg::CUR_W-1:0] ai_cur_i,
  input wire logic [sfdiag_pkg::CUR_W-1:0] lolo_thr_i,
  input wire logic [sfdiag_pkg::CUR_W-1:0] hihi_thr_i,
  input wire logic [sfdiag_pkg::CUR_W-1:0] disc_cur_i,
  // analog regions and flags
  output sfdiag_pkg::sfdiag_region_t ai_region_o,
  output sfdiag_pkg::sfdiag_region_t [2:0] ai_ch_region_o,
  output sfdiag_pkg::sfdiag_ai_flags_t ai_flags_o
);

  localparam int unsigned TP_HALF_CYC = TP_PERIOD_CYC / 2;
  localparam int unsigned TP_CNT_W = sfdiag_pkg::TP_CNT_W;

  sfdiag_pkg::sfdiag_state_t state_reg;
  sfdiag_pkg::sfdiag_state_t state_next;

  logic is_dual;
  logic tp_en;
  logic ext_ret;
  logic [1:0] act;
  logic [1:0] pulse;
  logic [1:0] pulse_end;
  logic [1:0] lvl_eff;
  logic [1:0] oc_eff;
  logic [2:0] over_thr;
  logic [1:0] hihi_cnt;
  logic d01_big;
  logic d02_big;
  logic d12_big;

  function automatic sfdiag_pkg::sfdiag_region_t classify(
    input logic [sfdiag_pkg::CUR_W-1:0] cur,
    input logic [sfdiag_pkg::CUR_W-1:0] lo,
    input logic [sfdiag_pkg::CUR_W-1:0] hi
  );
    sfdiag_pkg::sfdiag_region_t r;
    r = sfdiag_pkg::SFDIAG_REG_NORM;
    if (cur < lo)
      r = sfdiag_pkg::SFDIAG_REG_LOLO;
    else if (cur > hi)
      r = sfdiag_pkg::SFDIAG_REG_HIHI;
    return r;
  endfunction

  function automatic logic delta_big(
    input logic [sfdiag_pkg::CUR_W-1:0] a,
    input logic [sfdiag_pkg::CUR_W-1:0] b,
    input logic [sfdiag_pkg::CUR_W-1:0] lim
  );
    logic [sfdiag_pkg::CUR_W-1:0] d;
    d = (a > b) ? a - b : b - a;
    return d > lim;
  endfunction

  // median of three ordered regions is the two-of-three vote
  function automatic sfdiag_pkg::sfdiag_region_t vote3(
    input sfdiag_pkg::sfdiag_region_t a,
    input sfdiag_pkg::sfdiag_region_t b,
    input sfdiag_pkg::sfdiag_region_t c
  );
    sfdiag_pkg::sfdiag_region_t lo;
    sfdiag_pkg::sfdiag_region_t hi;
    sfdiag_pkg::sfdiag_region_t m;
    lo = (a < b) ? a : b;
    hi = (a < b) ? b : a;
    m = (hi < c) ? hi : c;
    return (lo > m) ? lo : m;
  endfunction

  always_comb
  begin
    is_dual = (do_mode_i == sfdiag_pkg::SFDIAG_DO_DUAL)
      || (do_mode_i == sfdiag_pkg::SFDIAG_DO_DUAL_INT_TP)
      || (do_mode_i == sfdiag_pkg::SFDIAG_DO_DUAL_EXT_TP);
    tp_en = (do_mode_i == sfdiag_pkg::SFDIAG_DO_SINGLE_INT_TP)
      || (do_mode_i == sfdiag_pkg::SFDIAG_DO_SINGLE_EXT_TP)
      || (do_mode_i == sfdiag_pkg::SFDIAG_DO_DUAL_INT_TP)
      || (do_mode_i == sfdiag_pkg::SFDIAG_DO_DUAL_EXT_TP);
    ext_ret = (do_mode_i == sfdiag_pkg::SFDIAG_DO_SINGLE_EXT_RB)
      || (do_mode_i == sfdiag_pkg::SFDIAG_DO_SINGLE_EXT_TP)
      || (do_mode_i == sfdiag_pkg::SFDIAG_DO_DUAL_EXT_TP);
    act = {is_dual, 1'b1};
    // the returning input channel is judged alongside output channel 0
    lvl_eff = {line_lvl_i[1] & act[1], line_lvl_i[0] | (ext_ret & ret_lvl_i)};
    oc_eff = {line_oc_i[1] & act[1], line_oc_i[0] | (ext_ret & ret_oc_i)};
    // channel 1 runs half a period behind so a short between channels is caught
    pulse[0] = tp_en && cmd_i
      && (state_reg.tp_cnt < TP_CNT_W'(TP_WIDTH_CYC));
    pulse[1] = tp_en && cmd_i && act[1]
      && (state_reg.tp_cnt >= TP_CNT_W'(TP_HALF_CYC))
      && (state_reg.tp_cnt < TP_CNT_W'(TP_HALF_CYC + TP_WIDTH_CYC));
    pulse_end[0] = pulse[0] && (state_reg.tp_cnt == TP_CNT_W'(TP_WIDTH_CYC - 1));
    pulse_end[1] = pulse[1]
      && (state_reg.tp_cnt == TP_CNT_W'(TP_HALF_CYC + TP_WIDTH_CYC - 1));
    over_thr[0] = ai_cur_i[0] > hihi_thr_i;
    over_thr[1] = ai_cur_i[1] > hihi_thr_i;
    over_thr[2] = ai_cur_i[2] > hihi_thr_i;
    hihi_cnt = 2'(over_thr[0]) + 2'(over_thr[1]) + 2'(over_thr[2]);
    d01_big = delta_big(ai_cur_i[0], ai_cur_i[1], disc_cur_i);
    d02_big = delta_big(ai_cur_i[0], ai_cur_i[2], disc_cur_i);
    d12_big = delta_big(ai_cur_i[1], ai_cur_i[2], disc_cur_i);
  end

  always_comb
  begin
    state_next = state_reg;
    // free-running pulse timebase
    if (state_reg.tp_cnt >= TP_CNT_W'(TP_PERIOD_CYC - 1))
      state_next.tp_cnt = sfdiag_pkg::TP_CNT_RST;
    else
      state_next.tp_cnt = state_reg.tp_cnt + 18'h00001;
    // a pulse only ever removes drive, never adds it
    state_next.drive = {2{cmd_i}} & act & ~pulse;
    state_next.do_flags.oc = cmd_i && (|oc_eff);
    state_next.do_flags.open = cmd_i && (|(act & ~line_load_i));
    state_next.do_flags.readback = !cmd_i && (|lvl_eff);
    // each channel keeps its own verdict until its own next pulse, so a clean pulse
    // on one channel cannot hide a line stuck high on the other
    if (!tp_en || !cmd_i)
      state_next.tp_bad = 2'h0;
    else
      state_next.tp_bad = (state_reg.tp_bad & ~pulse_end) | (pulse_end & lvl_eff);
    state_next.do_flags.test_pulse = |state_next.tp_bad;
    for (int k = 0; k < 3; k++)
      state_next.ch_region[k] = classify(ai_cur_i[k], lolo_thr_i, hihi_thr_i);
    state_next.ai_flags = '0;
    case (ai_mode_i)
      sfdiag_pkg::SFDIAG_AI_SINGLE:
      begin
        state_next.region = state_next.ch_region[0];
        state_next.ai_flags.overcurrent = over_thr[0];
      end
      sfdiag_pkg::SFDIAG_AI_1OO2:
      begin
        // low low wins since it is the de-energised safe region
        if ((state_next.ch_region[0] == sfdiag_pkg::SFDIAG_REG_LOLO)
            || (state_next.ch_region[1] == sfdiag_pkg::SFDIAG_REG_LOLO))
          state_next.region = sfdiag_pkg::SFDIAG_REG_LOLO;
        else if ((state_next.ch_region[0] == sfdiag_pkg::SFDIAG_REG_HIHI)
            || (state_next.ch_region[1] == sfdiag_pkg::SFDIAG_REG_HIHI))
          state_next.region = sfdiag_pkg::SFDIAG_REG_HIHI;
        else
          state_next.region = sfdiag_pkg::SFDIAG_REG_NORM;
        state_next.ai_flags.overcurrent = over_thr[0] || over_thr[1];
        state_next.ai_flags.disc_fault = d01_big;
      end
      sfdiag_pkg::SFDIAG_AI_2OO3:
      begin
        state_next.region = vote3(state_next.ch_region[0], state_next.ch_region[1],
          state_next.ch_region[2]);
        state_next.ai_flags.overcurrent = hihi_cnt >= 2'h2;
        // no agreeing pair left means the vote itself is untrusted
        state_next.ai_flags.disc_fault = d01_big && d02_big && d12_big;
        state_next.ai_flags.disc_warn = (d01_big || d02_big || d12_big)
          && !(d01_big && d02_big && d12_big);
      end
      default:
      begin
        state_next.region = sfdiag_pkg::SFDIAG_REG_LOLO;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      state_reg <= '0;
      state_reg.tp_cnt <= sfdiag_pkg::TP_CNT_RST;
      state_reg.drive <= sfdiag_pkg::DRIVE_RST;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign do_drive_o = state_reg.drive;
  assign do_flags_o = state_reg.do_flags;
  assign ai_region_o = state_reg.region;
  assign ai_ch_region_o = state_reg.ch_region;
  assign ai_flags_o = state_reg.ai_flags;

  a_oc_when_true: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    cmd_i && line_oc_i[0] |=> do_flags_o.oc)
    else $error("ground short while true gave no overcurrent");

  a_safe_when_false: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !cmd_i |=> !do_flags_o.oc && !do_flags_o.open && (do_drive_o == 2'h0))
    else $error("fault or drive while output false");

  a_open_when_true: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    cmd_i && !line_load_i[0] |=> do_flags_o.open)
    else $error("open line while true not flagged");

  a_readback_mismatch: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !cmd_i && line_lvl_i[0] |=> do_flags_o.readback && !do_flags_o.test_pulse)
    else $error("supply short while false not flagged as readback");

  a_pulse_staggered: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !(pulse[0] && pulse[1]))
    else $error("test pulses overlap on both channels");

  a_pulse_low_width: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    $rose(pulse[0]) && cmd_i |=> !do_drive_o[0])
    else $error("test pulse did not pull the line low");

  a_tp_fault_set: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    pulse_end[0] && line_lvl_i[0] |=> do_flags_o.test_pulse)
    else $error("line stuck high through pulse not flagged");

  a_region_lolo: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ai_cur_i[1] < lolo_thr_i |=> ai_ch_region_o[1] == sfdiag_pkg::SFDIAG_REG_LOLO)
    else $error("low current not classed low low");

  a_disc_1oo2: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ai_mode_i == sfdiag_pkg::SFDIAG_AI_1OO2 |=> ai_flags_o.disc_fault == $past(d01_big))
    else $error("one-of-two discrepancy does not follow delta");

  a_single_oc_2oo3: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ai_mode_i == sfdiag_pkg::SFDIAG_AI_2OO3 && hihi_cnt == 2'h1 |=> !ai_flags_o.overcurrent)
    else $error("single overcurrent in two-of-three raised overcurrent");

  a_ret_short_oc: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ext_ret && cmd_i && ret_oc_i |=> do_flags_o.oc)
    else $error("return channel ground short gave no overcurrent");

  a_no_rb_true: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    cmd_i |=> !do_flags_o.readback)
    else $error("readback fault raised while output true");

  a_tp_fault_ch1: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    pulse_end[1] && line_lvl_i[1] |=> do_flags_o.test_pulse)
    else $error("channel 1 stuck high through pulse not flagged");

  a_hihi_1oo2: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ai_mode_i == sfdiag_pkg::SFDIAG_AI_1OO2 && over_thr[0] && over_thr[1]
      |=> ai_region_o == sfdiag_pkg::SFDIAG_REG_HIHI && ai_flags_o.overcurrent)
    else $error("both channels over range not high high with overcurrent");

  a_all_oc_2oo3: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    ai_mode_i == sfdiag_pkg::SFDIAG_AI_2OO3 && hihi_cnt == 2'h3
      |=> ai_region_o == sfdiag_pkg::SFDIAG_REG_HIHI && ai_flags_o.overcurrent)
    else $error("three channels over range not high high with overcurrent");

  c_tp_fault: cover property (@(posedge sys_clk_i) disable iff (srst_i)
    $rose(do_flags_o.test_pulse));
  c_dual_pulses: cover property (@(posedge sys_clk_i) disable iff (srst_i)
    $fell(pulse[0]) ##[1:1000] pulse[1]);
  c_warn_2oo3: cover property (@(posedge sys_clk_i) disable iff (srst_i)
    ai_flags_o.disc_warn && ai_flags_o.overcurrent);
  c_ret_fault: cover property (@(posedge sys_clk_i) disable iff (srst_i)
    ext_ret && do_flags_o.test_pulse);
  c_disc_1oo2: cover property (@(posedge sys_clk_i) disable iff (srst_i)
    ai_flags_o.disc_fault && ai_region_o == sfdiag_pkg::SFDIAG_REG_LOLO);

endmodule

// *** tb/sfdiag_field.sv ***
// field wiring model: channel lines, injected faults and the returning input channel
`timescale 1ns/100ps
module sfdiag_field (
  // drive from the block
  input wire logic [1:0] drive_i,
  // injected wiring faults per channel, at most one kind per channel
  input wire logic [1:0] gnd_i,
  input wire logic [1:0] sup_i,
  input wire logic [1:0] open_i,
  input wire logic ret_gnd_i,
  input wire logic ret_sup_i,
  // sensed line conditions back to the block
  output logic [1:0] lvl_o,
  output logic [1:0] oc_o,
  output logic [1:0] load_o,
  output logic ret_lvl_o,
  output logic ret_oc_o
);
  // a supply short wins over the drive; a ground short pulls low and draws overcurrent
  assign lvl_o = sup_i | (drive_i & ~gnd_i);
  assign oc_o = drive_i & gnd_i;
  // load reports wiring continuity, so a test pulse alone never looks like an open line
  assign load_o = ~open_i;
  assign ret_lvl_o = ret_sup_i | (drive_i[0] & ~ret_gnd_i);
  assign ret_oc_o = drive_i[0] & ret_gnd_i;
endmodule

// *** tb/testbench.sv ***
// self-checking bench for the safety i/o diagnostic block
`timescale 1ns/100ps
module testbench;
  localparam int W = 4;
  localparam int P = 16;
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic cmd_i = 1'b0;
  sfdiag_pkg::sfdiag_do_mode_t do_mode_i = sfdiag_pkg::SFDIAG_DO_SINGLE;
  logic [1:0] line_lvl, line_oc, line_load, do_drive, exp_drive, drive_mask;
  logic ret_lvl, ret_oc;
  logic [1:0] gnd = 2'h0, sup = 2'h0, opn = 2'h0;
  logic ret_gnd = 1'b0, ret_sup = 1'b0;
  sfdiag_pkg::sfdiag_do_flags_t do_flags, exp_do, do_mask;
  sfdiag_pkg::sfdiag_ai_mode_t ai_mode = sfdiag_pkg::SFDIAG_AI_SINGLE;
  logic [2:0][sfdiag_pkg::CUR_W-1:0] cur = '0;
  logic [15:0] lolo = 16'h0400, hihi = 16'h5000, disc = 16'h0200;
  sfdiag_pkg::sfdiag_region_t region, exp_region;
  sfdiag_pkg::sfdiag_region_t [2:0] ch_region, exp_ch;
  sfdiag_pkg::sfdiag_ai_flags_t ai_flags, exp_ai;
  int num_errors = 0, n_compared = 0, seed = 32'h41b2, k, j, lo0, lo1, both;
  bit armed = 1'b0;

  always #2.5 sys_clk_i = ~sys_clk_i;

  sfdiag_field field (.drive_i(do_drive), .gnd_i(gnd), .sup_i(sup), .open_i(opn),
    .ret_gnd_i(ret_gnd), .ret_sup_i(ret_sup), .lvl_o(line_lvl), .oc_o(line_oc),
    .load_o(line_load), .ret_lvl_o(ret_lvl), .ret_oc_o(ret_oc));

  sfdiag_top #(.TP_WIDTH_CYC(W), .TP_PERIOD_CYC(P)) uut (.sys_clk_i(sys_clk_i),
    .srst_i(srst_i), .cmd_i(cmd_i), .do_mode_i(do_mode_i), .line_lvl_i(line_lvl),
    .line_oc_i(line_oc), .line_load_i(line_load), .ret_lvl_i(ret_lvl), .ret_oc_i(ret_oc),
    .do_drive_o(do_drive), .do_flags_o(do_flags), .ai_mode_i(ai_mode), .ai_cur_i(cur),
    .lolo_thr_i(lolo), .hihi_thr_i(hihi), .disc_cur_i(disc), .ai_region_o(region),
    .ai_ch_region_o(ch_region), .ai_flags_o(ai_flags));

  function automatic int reg_of(input logic [15:0] c);
    return (c < lolo) ? 0 : ((c > hihi) ? 2 : 1);
  endfunction

  function automatic bit far(input logic [15:0] a, input logic [15:0] b);
    return ((a > b) ? a - b : b - a) > disc;
  endfunction

  // reference model: flags and regions follow the inputs sampled one edge earlier
  always @(posedge sys_clk_i)
  begin
    int r0, r1, r2, lo, hi, nh;
    bit dual, ext, tp, f01, f02, f12;
    dual = do_mode_i >= sfdiag_pkg::SFDIAG_DO_DUAL;
    ext = do_mode_i inside {sfdiag_pkg::SFDIAG_DO_SINGLE_EXT_RB,
      sfdiag_pkg::SFDIAG_DO_SINGLE_EXT_TP, sfdiag_pkg::SFDIAG_DO_DUAL_EXT_TP};
    tp = do_mode_i inside {sfdiag_pkg::SFDIAG_DO_SINGLE_INT_TP,
      sfdiag_pkg::SFDIAG_DO_SINGLE_EXT_TP, sfdiag_pkg::SFDIAG_DO_DUAL_INT_TP,
      sfdiag_pkg::SFDIAG_DO_DUAL_EXT_TP};
    r0 = reg_of(cur[0]);
    r1 = reg_of(cur[1]);
    r2 = reg_of(cur[2]);
    lo = (r0 < r1) ? ((r0 < r2) ? r0 : r2) : ((r1 < r2) ? r1 : r2);
    hi = (r0 > r1) ? ((r0 > r2) ? r0 : r2) : ((r1 > r2) ? r1 : r2);
    nh = (r0 == 2) + (r1 == 2) + (r2 == 2);
    f01 = far(cur[0], cur[1]);
    f02 = far(cur[0], cur[2]);
    f12 = far(cur[1], cur[2]);
    if (srst_i)
    begin
      exp_do = '0;
      do_mask = '1;
      exp_drive = 2'h0;
      drive_mask = 2'h3;
      exp_ai = '0;
      exp_ch = '0;
      exp_region = sfdiag_pkg::SFDIAG_REG_LOLO;
    end
    else
    begin
      exp_do.oc = cmd_i & (line_oc[0] | dual & line_oc[1] | ext & ret_oc);
      exp_do.open = cmd_i & (~line_load[0] | dual & ~line_load[1]);
      exp_do.readback = ~cmd_i & (line_lvl[0] | dual & line_lvl[1] | ext & ret_lvl);
      exp_do.test_pulse = 1'b0;
      do_mask = {3'h7, ~(tp & cmd_i)};
      drive_mask = tp ? 2'h0 : 2'h3;
      exp_drive = {dual & cmd_i, cmd_i} & drive_mask;
      for (int i = 0; i < 3; i++)
        exp_ch[i] = sfdiag_pkg::sfdiag_region_t'(reg_of(cur[i]));
      case (ai_mode)
        sfdiag_pkg::SFDIAG_AI_1OO2:
        begin
          exp_region = sfdiag_pkg::sfdiag_region_t'((r0 == 0 || r1 == 0) ? 0
            : ((r0 == 2 || r1 == 2) ? 2 : 1));
          exp_ai = {r0 == 2 || r1 == 2, f01, 1'b0};
        end
        sfdiag_pkg::SFDIAG_AI_2OO3:
        begin
          exp_region = sfdiag_pkg::sfdiag_region_t'(r0 + r1 + r2 - lo - hi);
          exp_ai = {nh >= 2, f01 & f02 & f12, (f01 | f02 | f12) & ~(f01 & f02 & f12)};
        end
        default:
        begin
          exp_region = sfdiag_pkg::sfdiag_region_t'(r0);
          exp_ai = {r0 == 2, 2'h0};
        end
      endcase
    end
  end

  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  always @(negedge sys_clk_i)
    if (armed)
    begin
      check("do flags", 16'(do_flags & do_mask), 16'(exp_do));
      check("drive", 16'(do_drive & drive_mask), 16'(exp_drive));
      check("ai flags", 16'(ai_flags), 16'(exp_ai));
      check("ai region", 16'(region), 16'(exp_region));
      check("ch region", 16'(ch_region), 16'(exp_ch));
    end

  task automatic tp_case(input sfdiag_pkg::sfdiag_do_mode_t m, input logic [1:0] s,
    input logic rs);
    cmd_i = 1'b0;
    @(negedge sys_clk_i);
    do_mode_i = m;
    cmd_i = 1'b1;
    sup = s;
    ret_sup = rs;
    repeat (2 * P + 2) @(negedge sys_clk_i);
    check("tp fault", 16'(do_flags.test_pulse), 16'h1);
    sup = 2'h0;
    ret_sup = 1'b0;
  endtask

  task automatic wrap_up();
    if (num_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(negedge sys_clk_i);
    srst_i = 1'b0;
    armed = 1'b1;
    do_mode_i = sfdiag_pkg::SFDIAG_DO_DUAL_INT_TP;
    cmd_i = 1'b1;
    repeat (P) @(negedge sys_clk_i);
    lo0 = 0;
    lo1 = 0;
    both = 0;
    repeat (P)
    begin
      @(negedge sys_clk_i);
      lo0 += int'(do_drive[0] === 1'b0);
      lo1 += int'(do_drive[1] === 1'b0);
      both += int'(do_drive === 2'h0);
    end
    check("pulse low ch0", 16'(lo0), 16'(W));
    check("pulse low ch1", 16'(lo1), 16'(W));
    check("pulse overlap", 16'(both), 16'h0);
    check("tp clean", 16'(do_flags.test_pulse), 16'h0);
    tp_case(sfdiag_pkg::SFDIAG_DO_SINGLE_INT_TP, 2'h1, 1'b0);
    tp_case(sfdiag_pkg::SFDIAG_DO_DUAL_INT_TP, 2'h2, 1'b0);
    tp_case(sfdiag_pkg::SFDIAG_DO_SINGLE_EXT_TP, 2'h0, 1'b1);
    // a second reset in mid-run, with the output still commanded and pulses running
    srst_i = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    srst_i = 1'b0;
    repeat (4000)
    begin
      @(negedge sys_clk_i);
      k = $random(seed);
      if (k[1:0] == 2'h0)
      begin
        cmd_i = k[2];
        do_mode_i = sfdiag_pkg::sfdiag_do_mode_t'(k[5:3] % 3'h7);
        gnd = {k[9:8] == 2'h1, k[7:6] == 2'h1};
        sup = {k[9:8] == 2'h2, k[7:6] == 2'h2};
        opn = {k[9:8] == 2'h3, k[7:6] == 2'h3};
        ret_gnd = k[12:11] == 2'h1;
        ret_sup = k[12:11] == 2'h2;
        disc = {4'h0, k[27:20], 4'h0};
      end
      ai_mode = sfdiag_pkg::sfdiag_ai_mode_t'(k[14:13] % 2'h3);
      for (int i = 0; i < 3; i++)
      begin
        j = $random(seed);
        case (j[2:0])
          3'h0: cur[i] = 16'h0000;
          3'h1: cur[i] = lolo;
          3'h2: cur[i] = hihi;
          3'h3: cur[i] = hihi + 16'h0001;
          default: cur[i] = 16'(j[31:16]) % 16'h6000;
        endcase
      end
    end
    wrap_up();
  end

  initial
  begin
    #40000;
    num_errors++;
    wrap_up();
  end
endmodule
